// File: hw/isc_bus_ctrl.sv
// Behaviour
// - reservation disabled and bus busy: start request rejected, no start driven.
// - lost arbitration or released extension code counts as bus not used by us; the code detects neither arbitration loss nor extension codes.
// - start result flag settles within 5 clocks of the start request.
// - initial stop assume at 0: busy flag goes 1 on enable.
// - initial stop assume at 1: busy flag goes 0 on enable.
// - enable while data low and clock high counts as a start.
// - release bit drops participation, frees pins, withholds acknowledge; the code drives no acknowledge.
// - reserved start begins on shift write after stop interrupt.
// - without that shift write a reserved request stays waiting.
// - reservation enabled and bus free: start made at once, then wait state.
// - status register shows master state flag.
module isc_bus_ctrl (
	// clock, reset, enable
	input  wire logic            clk_sys_in,
	input  wire logic            sys_rst_in,
	input  wire logic            ce_in,
	// register port
	input  isc_pkg::isc_req_t    req_in,
	output logic [isc_pkg::DATA_W-1:0] rdata_out,
	// i2c pins
	input  wire logic            serial_clock_pin_in,
	input  wire logic            serial_data_pin_in,
	output isc_pkg::isc_pins_t   pins_out,
	// event to cpu
	output logic                 controller_irq_out
);
	import isc_pkg::*;

	// ************************************************************
	// link sampling
	// ************************************************************
	logic [2:0] scl_sync_q, scl_sync_d;
	logic [2:0] sda_sync_q, sda_sync_d;
	logic       scl_q, scl_d, sda_q, sda_d, sda_prev_q, sda_prev_d;
	logic       start_det, stop_det;

	// three stages, a change counts once stages two and three agree
	always_comb begin
		scl_sync_d = {scl_sync_q[1:0], serial_clock_pin_in};
		sda_sync_d = {sda_sync_q[1:0], serial_data_pin_in};
		scl_d      = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
		sda_d      = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
		sda_prev_d = sda_q;
	end

	// sampling registers
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (ce_in) begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_q      <= scl_d;
			sda_q      <= sda_d;
			sda_prev_q <= sda_prev_d;
		end
	end

	// edges of data while clock high
	assign start_det = scl_q & sda_prev_q & ~sda_q;
	assign stop_det  = scl_q & ~sda_prev_q & sda_q;

	// ************************************************************
	// registers and control
	// ************************************************************
	isc_state_t        state_q, state_d;
	logic [DATA_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] ctlb_q, ctlb_d, shift_q, shift_d;
	logic [DATA_W-1:0] wl_q, wl_d, wh_q, wh_d, rdata_q, rdata_d;
	logic              en_q, en_d, spie_q, spie_d;
	logic              stt_q, stt_d, spt_q, spt_d;
	logic              stcf_q, stcf_d, busy_q, busy_d;
	logic              stcen_q, stcen_d, rsvdis_q, rsvdis_d;
	logic              mst_q, mst_d, std_q, std_d, spd_q, spd_d;
	logic              irq_q, irq_d;
	isc_pins_t         pins_q, pins_d;
	logic              wr_a, wr_f, wr_s, en_rise, rel;

	assign wr_a    = req_in.wr & (req_in.addr == ADR_CTLA);
	assign wr_f    = req_in.wr & (req_in.addr == ADR_FLAG);
	assign wr_s    = req_in.wr & (req_in.addr == ADR_SHIFT);
	assign en_rise = wr_a & req_in.wdata[CA_EN] & ~en_q;
	assign rel     = wr_a & req_in.wdata[CA_REL] & en_q;

	// next values of all control state
	always_comb begin
		state_d  = state_q;
		cnt_d    = (cnt_q != REG_RST) ? cnt_q - CNT_ONE : cnt_q;
		ctlb_d   = ctlb_q;
		shift_d  = shift_q;
		wl_d     = wl_q;
		wh_d     = wh_q;
		en_d     = en_q;
		spie_d   = spie_q;
		stt_d    = stt_q;
		spt_d    = spt_q;
		stcf_d   = stcf_q;
		busy_d   = busy_q;
		stcen_d  = stcen_q;
		rsvdis_d = rsvdis_q;
		mst_d    = mst_q;
		std_d    = std_q;
		spd_d    = spd_q;
		irq_d    = 1'b0;
		rdata_d  = REG_RST;
		// bus state seen on the wires
		if (start_det) begin
			busy_d = 1'b1;
			std_d  = 1'b1;
			spd_d  = 1'b0;
		end else if (stop_det) begin
			busy_d = 1'b0;
			std_d  = 1'b0;
			spd_d  = 1'b1;
			irq_d  = spie_q;
		end
		// sequencer
		unique case (state_q)
			ISC_IDLE: begin
				if (stt_q) begin
					stt_d = 1'b0;
					if (!busy_q) begin
						state_d = ISC_START;
						cnt_d   = wl_q;
						mst_d   = 1'b1;
						stcf_d  = 1'b0;
					end else if (rsvdis_q) begin
						stcf_d = 1'b1;
					end else begin
						state_d = ISC_RSV;
						stcf_d  = 1'b0;
					end
				end else if (spt_q) begin
					state_d = ISC_STOP_A;
					cnt_d   = wl_q;
				end
			end
			ISC_START: begin
				if (cnt_q == REG_RST) begin
					state_d = ISC_HOLD;
					irq_d   = 1'b1;
				end
			end
			ISC_HOLD: begin
				stt_d = 1'b0;
				if (spt_q) begin
					state_d = ISC_STOP_A;
					cnt_d   = wl_q;
				end
			end
			ISC_STOP_A: begin
				if (cnt_q == REG_RST) begin
					state_d = ISC_STOP_B;
					cnt_d   = wh_q;
				end
			end
			ISC_STOP_B: begin
				if (cnt_q == REG_RST) begin
					state_d = ISC_STOP_C;
				end
			end
			ISC_STOP_C: begin
				state_d = ISC_IDLE;
				mst_d   = 1'b0;
				spt_d   = 1'b0;
			end
			ISC_RSV: begin
				// only a shift write on a free bus launches the start
				if (wr_s && !busy_q) begin
					state_d = ISC_START;
					cnt_d   = wl_q;
					mst_d   = 1'b1;
				end
			end
			default: begin
				state_d = ISC_IDLE;
			end
		endcase
		// release or disable abandons the transfer
		if (rel || !en_q) begin
			state_d = ISC_IDLE;
			mst_d   = 1'b0;
			stt_d   = 1'b0;
			spt_d   = 1'b0;
		end
		if (!en_q) begin
			busy_d = 1'b0;
		end
		// register writes, a set beats the hardware clear
		if (wr_a) begin
			en_d   = req_in.wdata[CA_EN];
			spie_d = req_in.wdata[CA_SPIE];
			if (req_in.wdata[CA_STT] && (en_q || en_rise)) begin
				stt_d = 1'b1;
			end
			if (req_in.wdata[CA_SPT] && (en_q || en_rise)) begin
				spt_d = 1'b1;
			end
		end
		if (en_rise) begin
			busy_d = stcen_q ? (scl_q & ~sda_q) : 1'b1;
		end
		if (wr_f) begin
			stcen_d  = req_in.wdata[FL_STCEN];
			rsvdis_d = req_in.wdata[FL_RSV];
		end
		if (req_in.wr && req_in.addr == ADR_CTLB) begin
			ctlb_d = req_in.wdata;
		end
		if (wr_s && busy_q == 1'b0) begin
			shift_d = req_in.wdata;
		end
		if (req_in.wr && req_in.addr == ADR_WL) begin
			wl_d = req_in.wdata;
		end
		if (req_in.wr && req_in.addr == ADR_WH) begin
			wh_d = req_in.wdata;
		end
		// read data for the next cycle
		if (req_in.rd) begin
			unique case (req_in.addr)
				ADR_CTLA:  rdata_d = {en_q, 1'b0, 1'b0, spie_q, 2'b00, stt_q, spt_q};
				ADR_CTLB:  rdata_d = ctlb_q;
				ADR_STAT:  rdata_d = {mst_q, 5'h00, std_q, spd_q};
				ADR_FLAG:  rdata_d = {stcf_q, busy_q, 4'h0, stcen_q, rsvdis_q};
				ADR_SHIFT: rdata_d = shift_q;
				ADR_WL:    rdata_d = wl_q;
				ADR_WH:    rdata_d = wh_q;
				default:   rdata_d = REG_RST;
			endcase
		end
		// open drain drive from next state
		pins_d.scl_out = 1'b0;
		pins_d.sda_out = 1'b0;
		pins_d.scl_oe  = (state_d == ISC_HOLD) || (state_d == ISC_STOP_A);
		pins_d.sda_oe  = (state_d == ISC_START) || (state_d == ISC_HOLD) ||
		                 (state_d == ISC_STOP_A) || (state_d == ISC_STOP_B);
	end

	// control registers
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q  <= ISC_IDLE;
			cnt_q    <= REG_RST;
			ctlb_q   <= REG_RST;
			shift_q  <= REG_RST;
			wl_q     <= WL_RST;
			wh_q     <= WL_RST;
			rdata_q  <= REG_RST;
			en_q     <= 1'b0;
			spie_q   <= 1'b0;
			stt_q    <= 1'b0;
			spt_q    <= 1'b0;
			stcf_q   <= 1'b0;
			busy_q   <= 1'b0;
			stcen_q  <= 1'b0;
			rsvdis_q <= 1'b0;
			mst_q    <= 1'b0;
			std_q    <= 1'b0;
			spd_q    <= 1'b0;
			irq_q    <= 1'b0;
			pins_q   <= '0;
		end else if (ce_in) begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			ctlb_q   <= ctlb_d;
			shift_q  <= shift_d;
			wl_q     <= wl_d;
			wh_q     <= wh_d;
			rdata_q  <= rdata_d;
			en_q     <= en_d;
			spie_q   <= spie_d;
			stt_q    <= stt_d;
			spt_q    <= spt_d;
			stcf_q   <= stcf_d;
			busy_q   <= busy_d;
			stcen_q  <= stcen_d;
			rsvdis_q <= rsvdis_d;
			mst_q    <= mst_d;
			std_q    <= std_d;
			spd_q    <= spd_d;
			irq_q    <= irq_d;
			pins_q   <= pins_d;
		end
	end

	assign rdata_out          = rdata_q;
	assign pins_out           = pins_q;
	assign controller_irq_out = irq_q;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in || !ce_in);

	sequence start_taken_s;
		state_q == ISC_IDLE && stt_q && en_q && !rel;
	endsequence

	reject_no_start_a: assert property (start_taken_s and busy_q && rsvdis_q |=>
		stcf_q && state_q == ISC_IDLE && !pins_q.sda_oe) else $error("busy start not rejected");
	start_result_a: assert property ($rose(stt_q) && en_q |-> ##[1:5] !stt_q)
		else $error("start request not settled in 5 clocks");
	busy_on_en_a: assert property (en_rise && !stcen_q |=> busy_q)
		else $error("busy not set on enable");
	free_on_en_a: assert property (en_rise && stcen_q && !(scl_q && !sda_q) |=> !busy_q)
		else $error("busy not cleared on enable");
	enable_start_a: assert property (en_rise && stcen_q && scl_q && !sda_q |=> busy_q)
		else $error("enable during start not seen");
	release_drop_a: assert property (rel |=> state_q == ISC_IDLE && !mst_q ##1 !pins_q.sda_oe)
		else $error("release did not free bus");
	free_start_a: assert property (start_taken_s and !busy_q |=> mst_q && !stcf_q
		##1 pins_q.sda_oe) else $error("free bus start missing");
	reserve_wait_a: assert property (state_q == ISC_RSV && !wr_s && en_q && !rel |=>
		state_q == ISC_RSV && !pins_q.sda_oe) else $error("reserve left without shift write");
	reserve_go_a: assert property (state_q == ISC_RSV && wr_s && !busy_q && !rel |=>
		state_q == ISC_START && mst_q) else $error("reserved start not launched");
	busy_track_a: assert property (en_q && !en_rise && start_det |=> busy_q)
		else $error("start detect missed");
	stop_track_a: assert property (en_q && !en_rise && stop_det && !start_det |=> !busy_q ##0 spd_q)
		else $error("stop detect missed");
	master_flag_a: assert property (state_q == ISC_HOLD |-> mst_q)
		else $error("master flag low in wait state");
endmodule : isc_bus_ctrl

// File: hw/isc_pkg.sv
package isc_pkg;
	// ************************************************************
	// bus widths and register map
	// ************************************************************
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADR_CTLA  = 3'h0;
	localparam logic [ADDR_W-1:0] ADR_CTLB  = 3'h1;
	localparam logic [ADDR_W-1:0] ADR_STAT  = 3'h2;
	localparam logic [ADDR_W-1:0] ADR_FLAG  = 3'h3;
	localparam logic [ADDR_W-1:0] ADR_SHIFT = 3'h4;
	localparam logic [ADDR_W-1:0] ADR_WL    = 3'h5;
	localparam logic [ADDR_W-1:0] ADR_WH    = 3'h6;
	// control_register_a bits
	localparam int unsigned CA_EN   = 7;
	localparam int unsigned CA_REL  = 6;
	localparam int unsigned CA_SPIE = 4;
	localparam int unsigned CA_STT  = 1;
	localparam int unsigned CA_SPT  = 0;
	// status_register bits
	localparam int unsigned ST_MSTS = 7;
	localparam int unsigned ST_STD  = 1;
	localparam int unsigned ST_SPD  = 0;
	// flag_register bits
	localparam int unsigned FL_STCF  = 7;
	localparam int unsigned FL_BSY   = 6;
	localparam int unsigned FL_STCEN = 1;
	localparam int unsigned FL_RSV   = 0;
	// reset values and counter step
	localparam logic [DATA_W-1:0] REG_RST = 8'h00;
	localparam logic [DATA_W-1:0] WL_RST  = 8'h04;
	localparam logic [DATA_W-1:0] CNT_ONE = 8'h01;
	// latest clock at which the start result is known
	localparam int unsigned START_RESULT_CLKS = 5;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		ISC_IDLE   = 3'h0,
		ISC_START  = 3'h1,
		ISC_HOLD   = 3'h3,
		ISC_STOP_A = 3'h2,
		ISC_STOP_B = 3'h6,
		ISC_STOP_C = 3'h7,
		ISC_RSV    = 3'h4
	} isc_state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} isc_req_t;
	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} isc_pins_t;
endpackage : isc_pkg

// File: tb/isc_bus_ctrl_test.sv
module isc_bus_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import isc_pkg::*;
	typedef struct {
		logic [2:0] a;
		logic [7:0] d;
		logic       w;
		logic [7:0] e;
	} isc_row_t;
	logic              clk_sys = 1'b0;
	logic              sys_rst = 1'b1;
	isc_req_t          req = '0;
	logic [DATA_W-1:0] rdata;
	isc_pins_t         pins;
	logic              irq;
	logic              m_scl_oe;
	logic              m_sda_oe;
	int                err_total = 0;
	int                comparisons = 0;
	// pulled-up open-drain wires
	wire logic scl_w = ~(pins.scl_oe | m_scl_oe);
	wire logic sda_w = ~(pins.sda_oe | m_sda_oe);
	isc_row_t rows[7] = '{
		'{ADR_CTLB, 8'h5a, 1'b1, 8'h5a},
		'{ADR_WL, 8'h00, 1'b0, 8'h04},
		'{ADR_WH, 8'h00, 1'b0, 8'h04},
		'{3'h7, 8'hff, 1'b1, 8'h00},
		'{ADR_STAT, 8'h00, 1'b0, 8'h00},
		'{ADR_FLAG, 8'h00, 1'b0, 8'h00},
		'{ADR_CTLA, 8'h12, 1'b1, 8'h10}};

	// system clock
	always #25 clk_sys = ~clk_sys;

	isc_bus_ctrl i_dut (
		.clk_sys_in         (clk_sys),
		.sys_rst_in         (sys_rst),
		.ce_in              (1'b1),
		.req_in             (req),
		.rdata_out          (rdata),
		.serial_clock_pin_in(scl_w),
		.serial_data_pin_in (sda_w),
		.pins_out           (pins),
		.controller_irq_out (irq)
	);
	isc_bus_model i_bus (
		.scl_in    (scl_w),
		.sda_in    (sda_w),
		.scl_oe_out(m_scl_oe),
		.sda_oe_out(m_sda_oe)
	);

	// ********
	// tasks
	// ********
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr_reg

	// data stand in the cycle after the read strobe
	task rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask : rchk

	// bounded poll of a register field
	task poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
		int i;
		// always read once, rdata is zero between reads
		rchk(a, 8'h00, 8'h00);
		for (i = 0; i < 60 && (rdata & m) !== v; i++) begin
			rchk(a, 8'h00, 8'h00);
		end
		chk(rdata & m, v);
		if ((rdata & m) !== v) wrap_up();
	endtask : poll

	// bounded wait for irq (sel 0) or data drive (sel 1)
	task wait_hi(input int sel, input int n);
		int i;
		logic hit;
		hit = 1'b0;
		for (i = 0; i < n && hit !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
			hit = (sel == 0) ? irq : pins.sda_oe;
		end
		chk({7'h00, hit}, 8'h01);
		if (hit !== 1'b1) wrap_up();
	endtask : wait_hi

	task done(input string s);
		$display("test %s done", s);
	endtask : done

	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// ********
	// main sequence
	// ********
	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		chk({4'h0, pins}, 8'h00);
		chk({irq, rdata[6:0]}, 8'h00);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
			rchk(rows[i].a, 8'hff, rows[i].e);
		end
		done("registers");
		wr_reg(ADR_CTLB, 8'h00);
		wr_reg(ADR_CTLA, 8'h80);
		rchk(ADR_FLAG, 8'hff, 8'h40);
		wr_reg(ADR_CTLA, 8'h81);
		poll(ADR_FLAG, 8'h40, 8'h00);
		poll(ADR_CTLA, 8'h01, 8'h00);
		done("initial stop");
		wr_reg(ADR_CTLA, 8'h82);
		wait_hi(0, 40);
		chk({6'h00, pins.scl_oe, pins.sda_oe}, 8'h03);
		rchk(ADR_FLAG, 8'h80, 8'h00);
		rchk(ADR_STAT, 8'h80, 8'h80);
		wr_reg(ADR_CTLA, 8'hc0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk({4'h0, pins}, 8'h00);
		rchk(ADR_STAT, 8'h80, 8'h00);
		wr_reg(ADR_CTLA, 8'h00);
		done("start and release");
		wr_reg(ADR_FLAG, 8'h02);
		wr_reg(ADR_CTLA, 8'h80);
		rchk(ADR_FLAG, 8'hff, 8'h02);
		wr_reg(ADR_CTLA, 8'h00);
		i_bus.hold_data_low();
		// let the low data level reach the sampler before enabling
		repeat (4) @(posedge clk_sys);
		wr_reg(ADR_CTLA, 8'h80);
		repeat (6) @(posedge clk_sys);
		rchk(ADR_FLAG, 8'hff, 8'h42);
		wr_reg(ADR_CTLA, 8'hc0);
		chk({4'h0, pins}, 8'h00);
		i_bus.stop_frame();
		poll(ADR_FLAG, 8'h40, 8'h00);
		done("stop assume");
		wr_reg(ADR_FLAG, 8'h01);
		i_bus.start_frame();
		poll(ADR_FLAG, 8'h40, 8'h40);
		wr_reg(ADR_CTLA, 8'h82);
		repeat (4) @(posedge clk_sys);
		rchk(ADR_FLAG, 8'h80, 8'h80);
		chk({7'h00, pins.sda_oe}, 8'h00);
		i_bus.stop_frame();
		poll(ADR_FLAG, 8'h40, 8'h00);
		done("rejected start");
		wr_reg(ADR_FLAG, 8'h00);
		i_bus.start_frame();
		poll(ADR_FLAG, 8'h40, 8'h40);
		wr_reg(ADR_CTLA, 8'h92);
		repeat (2 * WL_RST + 4) @(posedge clk_sys);
		rchk(ADR_STAT, 8'h80, 8'h00);
		wr_reg(ADR_SHIFT, 8'h55);
		rchk(ADR_SHIFT, 8'hff, 8'h00);
		chk({7'h00, pins.sda_oe}, 8'h00);
		i_bus.stop_frame();
		wait_hi(0, 60);
		rchk(ADR_STAT, 8'hff, 8'h01);
		repeat (20) @(posedge clk_sys);
		#1;
		chk({7'h00, pins.sda_oe}, 8'h00);
		wr_reg(ADR_SHIFT, 8'ha0);
		wait_hi(1, 30);
		rchk(ADR_STAT, 8'h80, 8'h80);
		done("reservation");
		// reset in mid transfer drops the pins and restores registers
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk({4'h0, pins}, 8'h00);
		chk({irq, rdata[6:0]}, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(ADR_CTLA, 8'hff, 8'h00);
		rchk(ADR_WL, 8'hff, WL_RST);
		done("mid-run reset");
		wrap_up();
	end
endmodule : isc_bus_ctrl_test

// File: tb/isc_bus_model.sv
// ********
// other master on the i2c lines
// ********
module isc_bus_model (
	// wire levels
	input  wire logic scl_in,
	input  wire logic sda_in,
	// open-drain pulls, high pulls low
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 200; // half a link clock period

	// lines start released
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// start: waits up to 20 half periods for a free bus, then clock pulses and clock held low
	task start_frame;
		int i;
		for (i = 0; i < 20 && !(scl_in && sda_in); i++) begin
			#HALF;
		end
		sda_oe_out = 1'b1;
		#HALF;
		repeat (2) begin
			scl_oe_out = 1'b1;
			#HALF;
			scl_oe_out = 1'b0;
			#HALF;
		end
		scl_oe_out = 1'b1;
	endtask : start_frame

	// data held low while clock stays high
	task hold_data_low;
		sda_oe_out = 1'b1;
	endtask : hold_data_low

	// stop: data rises while clock high, both end released
	task stop_frame;
		scl_oe_out = 1'b1;
		sda_oe_out = 1'b1;
		#HALF;
		scl_oe_out = 1'b0;
		#HALF;
		sda_oe_out = 1'b0;
	endtask : stop_frame
endmodule : isc_bus_model
